// file: verilog/dbs_boot_seq.sv
/*
 Host-side start-up sequencer for an audio DSP on a control port.
 Assumes the user streams configuration entries and the port writer
 answers each write with a done pulse.
*/
// How it works
// RULE_01 - Core stays halted while program and parameter memory are bulk loaded.
// RULE_02 - Running-core parameter tweaks may use the glitch-free safe-load path.
// RULE_03 - Device lets converters, audio interfaces, aux converters, core power down.
// RULE_04 - Nothing is written before the device reset is released.
// RULE_05 - Wait the initialization time after reset release before any write.
// RULE_06 - Then enable the clock gates of all modules in use.
// RULE_07 - Write 0x001C to the core rate select register to stop start pulses.
// RULE_08 - Then clear the core run bit so the core stays stopped.
// RULE_09 - Program serial input mode registers 0xE000 to 0xE008.
// RULE_10 - Program serial output mode registers 0xE040 to 0xE049.
// RULE_11 - Program routing matrix registers 0xE080 to 0xE09B.
// RULE_12 - Load parameter memory at 0x0000 to 0x0FFF.
// RULE_13 - Load program memory at 0x2000 to 0x2FFF.
// RULE_14 - Load data memory at addresses supplied with the image.
// RULE_15 - Then write remaining control registers 0xE221 to 0xE24C.
// RULE_16 - Write the operating rate value, which restarts the core start pulse.
// RULE_17 - Finally set the core run bit.
// RULE_18 - Run clear and all loads may go in any order; others are fixed.
// RULE_19 - Reference clock output gives 256x, 512x rate or buffered oscillator.
// RULE_20 - Output select 00 off, 01 oscillator, 10 256x, 11 512x.
// RULE_21 - Initialization lasts 2^15 crystal periods times the divider.
// RULE_22 - Completion shows only after the core run write is acknowledged.
// RULE_23 - Wait count comes from configurable crystal rate and divider.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_cfg.svh"
module dbs_boot_seq #(
	parameter int          DW           = 32,
	parameter int unsigned XTAL_HZ      = `DBS_XTAL_HZ,
	parameter int unsigned INIT_PERIODS = `DBS_INIT_XTAL_PERIODS
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// Sequence control
	input  wire logic             i_start,
	input  wire logic [2:0]       i_div_sel,
	input  wire logic [1:0]       i_clk_out_sel,
	input  wire logic [4:0]       i_clk_en,
	input  wire logic [15:0]      i_core_rate,
	output logic                  o_busy,
	output logic                  o_done,
	output logic                  o_err,
	// Configuration entries
	input  wire logic             i_ent_valid,
	output logic                  o_ent_ready,
	input  wire dbs_pkg::dbs_addr_t i_ent_addr,
	input  wire logic [DW-1:0]    i_ent_data,
	input  wire logic             i_ent_last,
	// Device pins
	output logic                  o_dev_reset_n,
	output logic [2:0]            o_divider_select,
	output logic                  o_clock_output_select_low,
	output logic                  o_clock_output_select_high,
	// Control port
	output logic                  o_cp_req,
	output dbs_pkg::dbs_addr_t    o_cp_addr,
	output logic [DW-1:0]         o_cp_data,
	input  wire logic             i_cp_ack
);
	import dbs_pkg::*;
	localparam logic [7:0] RST_CYC = 8'(`DBS_RST_CYC);

	dbs_wr_if #(.DW(DW)) wif ();

	dbs_state_t    st_q, st_d;
	dbs_addr_t     wa_q, wa_d;
	logic [DW-1:0] wd_q, wd_d;
	logic [7:0]    rcnt_q, rcnt_d;
	logic [2:0]    divs_q, divs_d;
	logic [1:0]    cks_q, cks_d;
	logic          iss_q, iss_d, busy_q, busy_d, last_q, last_d;
	logic          rst_q, rst_d, done_q, done_d, err_q, err_d;
	logic          tstart, t_done, take, legal, adv, in_mode, in_ctrl;

	////////////////////////////////////////////////////////////////
	// Initialization wait and port writer
	dbs_init_timer #(
		.XTAL_HZ     (XTAL_HZ),
		.INIT_PERIODS(INIT_PERIODS)
	) u_timer (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_start  (tstart),
		.i_div_sel(divs_q),
		.o_done   (t_done)
	);

	dbs_cp_writer #(.DW(DW)) u_writer (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.wr       (wif.eng),
		.o_cp_req (o_cp_req),
		.o_cp_addr(o_cp_addr),
		.o_cp_data(o_cp_data),
		.i_cp_ack (i_cp_ack)
	);

	////////////////////////////////////////////////////////////////
	// Entry classification
	always_comb begin
		// RULE_09 RULE_10 RULE_11 mode windows
		in_mode = (i_ent_addr >= `DBS_SI_LO && i_ent_addr <= `DBS_SI_HI) ||
			(i_ent_addr >= `DBS_SO_LO && i_ent_addr <= `DBS_SO_HI) ||
			(i_ent_addr >= `DBS_RT_LO && i_ent_addr <= `DBS_RT_HI);
		// RULE_15 control register window
		in_ctrl = i_ent_addr >= `DBS_CTRL_LO && i_ent_addr <= `DBS_CTRL_HI;
		o_ent_ready = (st_q == S_LOAD || st_q == S_CTRL) && !iss_q && !busy_q;
		take = o_ent_ready && i_ent_valid;
		// RULE_12 RULE_13 RULE_14 memory below register space
		legal = (st_q == S_LOAD) ? (i_ent_addr < `DBS_REG_BASE || in_mode) : in_ctrl;
		adv = (wif.done && last_q) || (take && !legal && i_ent_last);
	end

	////////////////////////////////////////////////////////////////
	// Sequence next state
	always_comb begin
		st_d = st_q;
		wa_d = wa_q;
		wd_d = wd_q;
		rcnt_d = rcnt_q;
		divs_d = divs_q;
		cks_d = cks_q;
		iss_d = 1'b0;
		busy_d = busy_q;
		last_d = last_q;
		rst_d = rst_q;
		done_d = done_q;
		err_d = err_q;
		tstart = 1'b0;
		if (iss_q)
			busy_d = 1'b1;
		if (wif.done)
			busy_d = 1'b0;
		case (st_q)
			S_IDLE, S_DONE: begin
				// RULE_21 divider pins set under reset
				if (i_start) begin
					st_d = S_RST;
					rcnt_d = 8'h0;
					divs_d = i_div_sel;
					cks_d = i_clk_out_sel;
					rst_d = 1'b1;
					done_d = 1'b0;
					err_d = 1'b0;
				end
			end
			S_RST: begin
				// RULE_04 release reset first
				if (rcnt_q == RST_CYC - 8'h1) begin
					st_d = S_WAIT;
					rst_d = 1'b0;
					tstart = 1'b1;
				end else begin
					rcnt_d = rcnt_q + 8'h1;
				end
			end
			S_WAIT: begin
				// RULE_05 wait then gate clocks
				if (t_done) begin
					st_d = S_CLKEN;
					// RULE_06 module clock gates
					wa_d = `DBS_CLK_EN_ADDR;
					wd_d = DW'(i_clk_en);
					iss_d = 1'b1;
				end
			end
			S_CLKEN: begin
				// RULE_07 suppress start pulse
				if (wif.done) begin
					st_d = S_HOLD;
					wa_d = `DBS_RATE_ADDR;
					wd_d = DW'(`DBS_RATE_HOLD);
					iss_d = 1'b1;
				end
			end
			S_HOLD: begin
				// RULE_08 clear core run
				if (wif.done) begin
					st_d = S_STOP;
					wa_d = `DBS_CORE_RUN_ADDR;
					wd_d = '0;
					iss_d = 1'b1;
				end
			end
			S_STOP: begin
				// RULE_01 loads only while halted
				if (wif.done)
					st_d = S_LOAD;
			end
			S_LOAD, S_CTRL: begin
				// RULE_02 direct writes, no safe-load
				// RULE_18 loads taken in stream order
				if (take && legal) begin
					wa_d = i_ent_addr;
					wd_d = i_ent_data;
					iss_d = 1'b1;
					last_d = i_ent_last;
				end else if (take) begin
					err_d = 1'b1;
				end
				if (adv) begin
					last_d = 1'b0;
					if (st_q == S_LOAD) begin
						st_d = S_CTRL;
					end else begin
						// RULE_16 operating rate value
						st_d = S_RATE;
						wa_d = `DBS_RATE_ADDR;
						wd_d = DW'(i_core_rate);
						iss_d = 1'b1;
					end
				end
			end
			S_RATE: begin
				// RULE_17 set core run last
				if (wif.done) begin
					st_d = S_RUN;
					wa_d = `DBS_CORE_RUN_ADDR;
					wd_d = '0;
					wd_d[`DBS_CORE_RUN_BIT] = 1'b1;
					iss_d = 1'b1;
				end
			end
			S_RUN: begin
				// RULE_22 done after run ack
				if (wif.done) begin
					st_d = S_DONE;
					done_d = 1'b1;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_q <= S_IDLE;
			wa_q <= 16'h0;
			wd_q <= '0;
			rcnt_q <= 8'h0;
			divs_q <= 3'h0;
			cks_q <= 2'h0;
			iss_q <= 1'b0;
			busy_q <= 1'b0;
			last_q <= 1'b0;
			rst_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
			rcnt_q <= rcnt_d;
			divs_q <= divs_d;
			cks_q <= cks_d;
			iss_q <= iss_d;
			busy_q <= busy_d;
			last_q <= last_d;
			rst_q <= rst_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs and writer requests
	assign wif.req = iss_q;
	assign wif.addr = wa_q;
	assign wif.data = wd_q;
	assign o_dev_reset_n = !rst_q;
	assign o_divider_select = divs_q;
	// RULE_20 output select pins
	assign o_clock_output_select_low = cks_q[0];
	assign o_clock_output_select_high = cks_q[1];
	assign o_busy = st_q != S_IDLE && st_q != S_DONE;
	assign o_done = done_q;
	assign o_err = err_q;

	////////////////////////////////////////////////////////////////
	// Checks
	chk_no_write_reset : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_04
		!o_dev_reset_n |-> !wif.req && !o_cp_req) else $error("write during device reset");
	chk_wait_no_write : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_05
		st_q == S_WAIT |-> !o_cp_req && !wif.req) else $error("write before init wait");
	chk_clk_gate_first : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_06
		$rose(st_q == S_CLKEN) |-> $past(t_done) && wa_q == `DBS_CLK_EN_ADDR) else $error("clock gate write");
	chk_hold_value : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_07
		st_q == S_HOLD && wif.req |-> wa_q == `DBS_RATE_ADDR && wd_q == DW'(`DBS_RATE_HOLD))
		else $error("hold write wrong");
	chk_stop_clear : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_08
		st_q == S_STOP && wif.req |-> wa_q == `DBS_CORE_RUN_ADDR && !wd_q[`DBS_CORE_RUN_BIT])
		else $error("run clear wrong");
	chk_load_range : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_09 RULE_10 RULE_11
		st_q == S_LOAD && wif.req |-> wa_q < `DBS_REG_BASE || (wa_q >= `DBS_SI_LO && wa_q <= `DBS_SI_HI) ||
			(wa_q >= `DBS_SO_LO && wa_q <= `DBS_SO_HI) || (wa_q >= `DBS_RT_LO && wa_q <= `DBS_RT_HI))
		else $error("load address");
	chk_ctrl_range : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_15
		st_q == S_CTRL && wif.req |-> wa_q >= `DBS_CTRL_LO && wa_q <= `DBS_CTRL_HI) else $error("ctrl address");
	chk_rate_restart : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_16
		st_q == S_RATE && wif.req |-> wa_q == `DBS_RATE_ADDR && wd_q == DW'(i_core_rate))
		else $error("rate write wrong");
	chk_run_set : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_17
		st_q == S_RUN && wif.req |-> wa_q == `DBS_CORE_RUN_ADDR && wd_q[`DBS_CORE_RUN_BIT]) else $error("run set");
	chk_done_after_ack : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_22
		$rose(o_done) |-> $past(st_q) == S_RUN && $past(wif.done)) else $error("done before run ack");
endmodule
`default_nettype wire

// file: verilog/dbs_cfg.svh
/*
 Addresses, values and timing counts of the start-up sequencer.
 Assumes a 16-bit register address space on the device control port.
*/
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH

// Core rate select register and its start-pulse hold value
`define DBS_RATE_ADDR 16'he220
`define DBS_RATE_HOLD 16'h001c
// Remaining control registers
`define DBS_CTRL_LO 16'he221
`define DBS_CTRL_HI 16'he24c
// Module clock gate and core run registers
`define DBS_CLK_EN_ADDR 16'he22a
`define DBS_CORE_RUN_ADDR 16'he228
`define DBS_CORE_RUN_BIT 0
// Mode register windows open during loading
`define DBS_REG_BASE 16'he000
`define DBS_SI_LO 16'he000
`define DBS_SI_HI 16'he008
`define DBS_SO_LO 16'he040
`define DBS_SO_HI 16'he049
`define DBS_RT_LO 16'he080
`define DBS_RT_HI 16'he09b
// Clock rates and initialization length
`define DBS_CLK_HZ 25000000
`define DBS_CLK_MHZ 25
`define DBS_XTAL_HZ 12288000
`define DBS_INIT_XTAL_PERIODS 32768
// Device reset pulse width
`define DBS_RST_LOW_NS 2000
`define DBS_RST_CYC ((`DBS_RST_LOW_NS * `DBS_CLK_MHZ + 999) / 1000)

`endif

// file: verilog/dbs_pkg.sv
/*
 Types shared by the start-up sequencer modules.
 Assumes dbs_cfg.svh for the numeric constants.
*/
`default_nettype none
package dbs_pkg;
	typedef logic [15:0] dbs_addr_t;
	typedef enum logic [3:0] {
		S_IDLE, S_RST, S_WAIT, S_CLKEN, S_HOLD, S_STOP,
		S_LOAD, S_CTRL, S_RATE, S_RUN, S_DONE
	} dbs_state_t;
endpackage
`default_nettype wire

// file: verilog/dbs_wr_if.sv
/*
 Write request carrier between the sequencer and the control port writer.
 Assumes req is a one-cycle pulse and done a one-cycle pulse per write.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbs_wr_if #(parameter int DW = 32) ();
	logic              req;
	dbs_pkg::dbs_addr_t addr;
	logic [DW-1:0]     data;
	logic              done;
	modport seq (output req, addr, data, input done);
	modport eng (input req, addr, data, output done);
endinterface
`default_nettype wire

// file: verilog/dbs_init_timer.sv
/*
 Counts the device initialization period in crystal periods.
 Assumes XTAL_HZ is not above CLK_HZ; a phase accumulator makes crystal ticks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbs_cfg.svh"
module dbs_init_timer #(
	parameter int unsigned CLK_HZ       = `DBS_CLK_HZ,
	parameter int unsigned XTAL_HZ      = `DBS_XTAL_HZ,
	parameter int unsigned INIT_PERIODS = `DBS_INIT_XTAL_PERIODS
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// Control
	input  wire logic       i_start,
	input  wire logic [2:0] i_div_sel,
	output logic            o_done
);
	import dbs_pkg::*;
	localparam int CW = $clog2(8 * INIT_PERIODS) + 1;

	logic [31:0]   acc_q, acc_d;
	logic [32:0]   sum;
	logic [CW-1:0] cnt_q, cnt_d, target;
	logic [3:0]    dfac;
	logic          run_q, run_d, done_q, done_d, tick;

	////////////////////////////////////////////////////////////////
	// Divider factor from the select pins, unused codes take the longest
	always_comb begin
		case (i_div_sel)
			3'h0: dfac = 4'h1;
			3'h1: dfac = 4'h2;
			3'h2: dfac = 4'h4;
			3'h3: dfac = 4'h6;
			default: dfac = 4'h8;
		endcase
	end

	// Crystal tick enable and period count
	// RULE_23 wait from crystal rate
	always_comb begin
		target = CW'(dfac) * CW'(INIT_PERIODS);
		sum = {1'b0, acc_q} + 33'(XTAL_HZ);
		tick = sum >= 33'(CLK_HZ);
		acc_d = tick ? 32'(sum - 33'(CLK_HZ)) : sum[31:0];
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = done_q;
		if (i_start) begin
			acc_d = 32'h0;
			cnt_d = '0;
			run_d = 1'b1;
			done_d = 1'b0;
		end else if (run_q) begin
			if (cnt_q == target) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end else if (tick) begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			acc_q <= 32'h0;
			cnt_q <= '0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end

	assign o_done = done_q;

	// Init wait ends only on the full count
	chk_timer_full_count : assert property (@(posedge i_clk) disable iff (i_reset) // RULE_21 RULE_23
		$rose(done_q) |-> $past(cnt_q) == $past(target)) else $error("init wait ended early");
endmodule
`default_nettype wire

// file: verilog/dbs_cp_writer.sv
/*
 Drives one write at a time onto the device control port.
 Assumes the serial link below answers each request with a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module dbs_cp_writer #(
	parameter int DW = 32
) (
	// Clock and reset
	input  wire logic           i_clk,
	input  wire logic           i_reset,
	// Sequencer side
	dbs_wr_if.eng               wr,
	// Control port side
	output logic                o_cp_req,
	output dbs_pkg::dbs_addr_t  o_cp_addr,
	output logic [DW-1:0]       o_cp_data,
	input  wire logic           i_cp_ack
);
	import dbs_pkg::*;

	logic          req_q, req_d, done_q, done_d;
	dbs_addr_t     addr_q, addr_d;
	logic [DW-1:0] data_q, data_d;

	////////////////////////////////////////////////////////////////
	// Latch a request, hold it until the port acknowledges
	always_comb begin
		req_d = req_q;
		addr_d = addr_q;
		data_d = data_q;
		done_d = 1'b0;
		if (req_q && i_cp_ack) begin
			req_d = 1'b0;
			done_d = 1'b1;
		end else if (!req_q && wr.req) begin
			req_d = 1'b1;
			addr_d = wr.addr;
			data_d = wr.data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			req_q <= 1'b0;
			addr_q <= 16'h0;
			data_q <= '0;
			done_q <= 1'b0;
		end else begin
			req_q <= req_d;
			addr_q <= addr_d;
			data_q <= data_d;
			done_q <= done_d;
		end
	end

	assign o_cp_req = req_q;
	assign o_cp_addr = addr_q;
	assign o_cp_data = data_q;
	assign wr.done = done_q;

	chk_req_held_ack : assert property (@(posedge i_clk) disable iff (i_reset)
		o_cp_req && !i_cp_ack |=> o_cp_req && $stable(o_cp_addr)) else $error("request dropped early");
endmodule
`default_nettype wire

// file: sim/dbs_dev_model.sv
/*
 Behavioural audio DSP on the control port: acks writes, logs them, keeps rate, run and clock gates.
 Assumes one write at a time with the request held until its ack.
*/
`timescale 1ns/1ps
`default_nettype none
module dbs_dev_model #(
	parameter int INIT_PERIODS = 16,
	parameter int XTAL_HZ      = 12288000,
	parameter int CORE_GATE    = 4
) (
	// Clock and device pins
	input  wire logic        i_clk,
	input  wire logic        i_dev_reset_n,
	input  wire logic [2:0]  i_div_sel,
	input  wire logic        i_sel_low,
	input  wire logic        i_sel_high,
	input  wire logic        i_slow,
	// Control port
	input  wire logic        i_cp_req,
	input  wire logic [15:0] i_cp_addr,
	input  wire logic [31:0] i_cp_data,
	output logic             o_cp_ack = 1'b0,
	// State seen by the bench
	output logic             o_start_en,
	output logic             o_running,
	output logic [1:0]       o_refclk_mode
);
	logic [15:0] log_a [0:63];
	logic [31:0] log_d [0:63];
	logic [15:0] rate_q = 16'h0000;
	logic [4:0]  gate_q = 5'h00;
	logic        run_q  = 1'b0;
	int          n_log  = 0;
	int          n_early = 0;
	int          wait_q = 0;
	int          init_q = 0;
	longint      init_cyc;
	int          dv;

	always_comb begin
		case (i_div_sel)
			3'h0: dv = 1;
			3'h1: dv = 2;
			3'h2: dv = 4;
			3'h3: dv = 6;
			default: dv = 8;
		endcase
		init_cyc = (longint'(dv) * INIT_PERIODS * 25000000 + XTAL_HZ - 1) / XTAL_HZ;
	end

	// Ack after one or five cycles; registers cleared while device reset is low
	always @(posedge i_clk) begin
		if (i_cp_req && !o_cp_ack && wait_q < (i_slow ? 4 : 0)) begin
			wait_q <= wait_q + 1;
		end else if (i_cp_req && !o_cp_ack) begin
			o_cp_ack <= 1'b1;
			wait_q <= 0;
			log_a[n_log] <= i_cp_addr;
			log_d[n_log] <= i_cp_data;
			n_log <= n_log + 1;
			if (init_q < init_cyc)
				n_early <= n_early + 1;
			if (i_cp_addr == 16'he220)
				rate_q <= i_cp_data[15:0];
			if (i_cp_addr == 16'he228)
				run_q <= i_cp_data[0];
			if (i_cp_addr == 16'he22a)
				gate_q <= i_cp_data[4:0];
		end else begin
			o_cp_ack <= 1'b0;
		end
		init_q <= (init_q < init_cyc) ? init_q + 1 : init_q;
		if (!i_dev_reset_n) begin
			init_q <= 0;
			rate_q <= 16'h0000;
			gate_q <= 5'h00;
			run_q <= 1'b0;
		end
	end

	// start pulse held off by the hold value
	assign o_start_en = (rate_q != 16'h001c);
	// core runs only with its gate open
	assign o_running = run_q && o_start_en && gate_q[CORE_GATE];
	assign o_refclk_mode = {i_sel_high, i_sel_low};
endmodule
`default_nettype wire

// file: sim/tb_dbs_boot_seq.sv
/*
 Self-checking bench for the start-up sequencer: four boot runs against the device model.
 Assumes dbs_cfg.svh on the include path and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbs_cfg.svh"
module tb_dbs_boot_seq;
	import dbs_pkg::*;
	localparam int INIT = 16;
	logic        i_clk = 1'b0, i_reset = 1'b1, i_start = 1'b0, slow = 1'b0;
	logic        i_ent_valid = 1'b0, i_ent_last = 1'b0;
	logic [2:0]  i_div_sel = 3'h0;
	logic [1:0]  i_clk_out_sel = 2'h0;
	logic [4:0]  i_clk_en = 5'h00;
	logic [15:0] i_core_rate = 16'h0000;
	dbs_addr_t   i_ent_addr = 16'h0000;
	logic [31:0] i_ent_data = 32'h0;
	logic        o_busy, o_done, o_err, o_ent_ready, o_dev_reset_n, o_lo, o_hi, o_cp_req, i_cp_ack;
	logic [2:0]  o_divider_select;
	dbs_addr_t   o_cp_addr;
	logic [31:0] o_cp_data;
	logic [47:0] exp_q [$];
	logic [15:0] la [0:11] = '{16'he000, 16'he008, 16'he040, 16'he049, 16'he080, 16'he09b,
		16'h0000, 16'h0fff, 16'h2000, 16'he009, 16'h2fff, 16'h0abc};
	int          mismatches = 0, n_tests = 0, cycles = 0, base = 0, i;

	dbs_boot_seq #(.DW(32), .XTAL_HZ(12288000), .INIT_PERIODS(INIT)) DUT (.i_clk(i_clk), .i_reset(i_reset),
		.i_start(i_start), .i_div_sel(i_div_sel), .i_clk_out_sel(i_clk_out_sel), .i_clk_en(i_clk_en),
		.i_core_rate(i_core_rate), .o_busy(o_busy), .o_done(o_done), .o_err(o_err),
		.i_ent_valid(i_ent_valid), .o_ent_ready(o_ent_ready), .i_ent_addr(i_ent_addr),
		.i_ent_data(i_ent_data), .i_ent_last(i_ent_last), .o_dev_reset_n(o_dev_reset_n),
		.o_divider_select(o_divider_select), .o_clock_output_select_low(o_lo),
		.o_clock_output_select_high(o_hi), .o_cp_req(o_cp_req), .o_cp_addr(o_cp_addr),
		.o_cp_data(o_cp_data), .i_cp_ack(i_cp_ack));
	dbs_dev_model #(.INIT_PERIODS(INIT), .XTAL_HZ(12288000), .CORE_GATE(4)) DEV (.i_clk(i_clk),
		.i_dev_reset_n(o_dev_reset_n), .i_div_sel(o_divider_select), .i_sel_low(o_lo), .i_sel_high(o_hi),
		.i_slow(slow), .i_cp_req(o_cp_req), .i_cp_addr(o_cp_addr), .i_cp_data(o_cp_data),
		.o_cp_ack(i_cp_ack), .o_start_en(), .o_running(), .o_refclk_mode());

	initial begin
		forever #20 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare, verdict and hang guard
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Entry hand-off; refused entries are not expected on the port
	task automatic send(input logic [15:0] a, input logic [31:0] d, input logic last, input logic ok);
		int k;
		@(posedge i_clk);
		#1;
		i_ent_addr = a;
		i_ent_data = d;
		i_ent_last = last;
		i_ent_valid = 1'b1;
		k = 0;
		while (o_ent_ready !== 1'b1 && k < 3000) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		@(posedge i_clk);
		#1;
		i_ent_valid = 1'b0;
		if (ok)
			exp_q.push_back({a, d});
		check("entry taken", k < 3000, 1'b1);
	endtask

	// Start a boot and follow device reset and the init wait
	task automatic run(input logic [2:0] ds, input logic [1:0] cs, input logic [4:0] en,
		input logic [15:0] rate, input int d);
		int n;
		longint lo;
		@(posedge i_clk);
		#1;
		i_div_sel = ds;
		i_clk_out_sel = cs;
		i_clk_en = en;
		i_core_rate = rate;
		i_start = 1'b1;
		@(posedge i_clk);
		#1;
		i_start = 1'b0;
		base = DEV.n_log;
		exp_q = {};
		exp_q.push_back({16'he22a, 27'h0, en});
		exp_q.push_back({16'he220, 32'h1c});
		exp_q.push_back({16'he228, 32'h0});
		n = 0;
		while (o_dev_reset_n === 1'b0 && n < 200) begin
			check("req in reset", o_cp_req, 1'b0);
			check("pins", {o_busy, o_divider_select, o_hi, o_lo}, {1'b1, ds, cs});
			@(posedge i_clk);
			#1;
			n++;
		end
		check("reset width", n, `DBS_RST_CYC);
		lo = (longint'(d) * INIT * 25000000 + 12287999) / 12288000;
		n = 0;
		while (o_cp_req !== 1'b1 && n < 5000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		check("init wait", n >= lo && n <= lo + 6, 1'b1);
	endtask

	// Wait for completion and compare the write log
	task automatic fin(input logic [15:0] rate, input logic [1:0] cs, input logic err);
		int k;
		exp_q.push_back({16'he220, 16'h0, rate});
		exp_q.push_back({16'he228, 32'h1});
		k = 0;
		while (o_done !== 1'b1 && k < 3000) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		check("done after run ack", {o_done, DEV.run_q}, 2'h3);
		check("write count", DEV.n_log - base, exp_q.size());
		for (k = 0; k < exp_q.size(); k++)
			check("write", {DEV.log_a[base + k], DEV.log_d[base + k]}, exp_q[k]);
		check("early writes", DEV.n_early, 0);
		check("flags", {o_busy, o_err}, {1'b0, err});
		check("core running", DEV.o_running, 1'b1);
		check("refclk mode", DEV.o_refclk_mode, cs);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge i_clk);
		#1;
		i_reset = 1'b0;
		check("after reset", {o_dev_reset_n, o_busy, o_done, o_cp_req}, 4'h8);
		// Divider 4, 256x output, prompt acks, refused entries at window edges
		run(3'h2, 2'h2, 5'h1f, 16'h0001, 4);
		for (i = 0; i < 12; i++) begin
			send(la[i], 32'h100 + i, i == 11, la[i] != 16'he009);
			if (i == 0)
				check("held core", {DEV.o_start_en, DEV.run_q}, 2'h0);
		end
		send(16'he221, 32'h21, 1'b0, 1'b1);
		send(16'he220, 32'h20, 1'b0, 1'b0);
		send(16'he24c, 32'h4c, 1'b0, 1'b1);
		send(16'he24d, 32'h4d, 1'b1, 1'b0);
		fin(16'h0001, 2'h2, 1'b1);
		// Divider 1, buffered oscillator, slow acks, a start while busy
		slow = 1'b1;
		run(3'h0, 2'h1, 5'h11, 16'h0002, 1);
		@(posedge i_clk);
		#1;
		i_start = 1'b1;
		@(posedge i_clk);
		#1;
		i_start = 1'b0;
		send(16'h1000, 32'hdeadbeef, 1'b0, 1'b1);
		send(16'h0000, 32'h5, 1'b1, 1'b1);
		send(16'he230, 32'h30, 1'b1, 1'b1);
		fin(16'h0002, 2'h1, 1'b0);
		// Divider 6 and 8, 512x and disabled output, a refused last entry ends the load phase
		run(3'h3, 2'h3, 5'h10, 16'h0004, 6);
		send(16'h0fff, 32'h7, 1'b1, 1'b1);
		send(16'he24c, 32'h8, 1'b1, 1'b1);
		fin(16'h0004, 2'h3, 1'b0);
		run(3'h5, 2'h0, 5'h10, 16'h0008, 8);
		send(16'hf000, 32'h9, 1'b1, 1'b0);
		send(16'he221, 32'ha, 1'b1, 1'b1);
		fin(16'h0008, 2'h0, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
